// File: adsc_pkg.sv
// Constants, register map and types for the source and option configuration block
package adsc_pkg;
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned BAUD_4800   = 4800;
  localparam int unsigned BAUD_9600   = 9600;
  localparam int unsigned BAUD_19200  = 19200;
  localparam int unsigned BAUD_38400  = 38400;
  localparam int unsigned MSG_WIN_S   = 2;
  localparam int unsigned DIV_W       = 16;

  // Register byte addresses
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STAT   = 8'h04;
  localparam logic [7:0] A_OFS0   = 8'h08;
  localparam logic [7:0] A_OFS4   = 8'h18;
  localparam logic [7:0] A_RXDATA = 8'h1c;
  localparam logic [7:0] A_ALT    = 8'h20;

  // CTRL fields
  localparam int unsigned C_GND    = 0;
  localparam int unsigned C_REM_LO = 1;
  localparam int unsigned C_OPT_LO = 4;
  localparam int unsigned C_SIL    = 8;
  localparam int unsigned C_NAC    = 9;
  localparam logic [9:0]  CTRL_RST = 10'h000;

  // Remote head modes
  localparam logic [1:0] REM_OFF  = 2'h0;
  localparam logic [1:0] REM_ON   = 2'h1;
  localparam logic [1:0] REM_TEST = 2'h2;

  // Serial protocol options
  localparam logic [2:0] OPT_DISABLED  = 3'h0;
  localparam logic [2:0] OPT_AVNAV     = 3'h1;
  localparam logic [2:0] OPT_NMEA_SLOW = 3'h2;
  localparam logic [2:0] OPT_NMEA_FAST = 3'h3;
  localparam logic [2:0] OPT_NMEA_INT  = 3'h4;
  localparam logic [2:0] OPT_INTEG     = 3'h5;
  localparam logic [2:0] OPT_COMMAB    = 3'h6;

  // Display letters
  localparam logic [7:0] LETTER_G = 8'h47;
  localparam logic [7:0] LETTER_F = 8'h46;
  localparam logic [7:0] MSG_END  = 8'h0a;

  // Altitude correction: points in feet, offset in 10 ft steps
  localparam int         N_PTS    = 5;
  localparam int         STEP_FT  = 10;
  localparam logic signed [4:0] OFS_MAX = 5'sd10;
  localparam logic signed [4:0] OFS_MIN = -5'sd10;
  localparam int         PT0 = 2000;
  localparam int         PT1 = 8000;
  localparam int         PT2 = 18000;
  localparam int         PT3 = 25000;
  localparam int         PT4 = 35000;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } adsc_rx_state_t;

  function automatic int pt_ft(input int i);
    case (i)
      0: pt_ft = PT0;
      1: pt_ft = PT1;
      2: pt_ft = PT2;
      3: pt_ft = PT3;
      default: pt_ft = PT4;
    endcase
  endfunction
endpackage

// File: adsc_rx_if.sv
// Carrier between the configuration top and its serial receiver
interface adsc_rx_if;
  logic [adsc_pkg::DIV_W-1:0] baud_div;
  logic                       enable;
  logic                       rxd;
  logic [7:0]                 data;
  logic                       valid;
  logic                       frame_err;

  modport rx  (input baud_div, enable, rxd, output data, valid, frame_err);
  modport ctl (output baud_div, enable, rxd, input data, valid, frame_err);
endinterface

// File: adsc_uart_rx.sv
// 8N1 serial receiver sampling each bit at mid-period
module adsc_uart_rx (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  adsc_rx_if.rx    rxp
);
  adsc_pkg::adsc_rx_state_t state_ff;
  adsc_pkg::adsc_rx_state_t nxt_state;
  logic [adsc_pkg::DIV_W-1:0] cnt_ff;
  logic [adsc_pkg::DIV_W-1:0] nxt_cnt;
  logic [2:0]                 bit_ff;
  logic [2:0]                 nxt_bit;
  logic [7:0]                 sh_ff;
  logic [7:0]                 nxt_sh;
  logic [7:0]                 data_ff;
  logic                       valid_ff;
  logic                       ferr_ff;

  wire tick     = (cnt_ff == '0);
  wire stop_ok  = (state_ff == adsc_pkg::RX_STOP) && tick && rxp.rxd;
  wire stop_bad = (state_ff == adsc_pkg::RX_STOP) && tick && !rxp.rxd;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = tick ? cnt_ff : cnt_ff - 1'b1;
    nxt_bit   = bit_ff;
    nxt_sh    = sh_ff;
    case (state_ff)
      adsc_pkg::RX_IDLE:
      begin
        if (!rxp.rxd)
        begin
          nxt_state = adsc_pkg::RX_START;
          nxt_cnt   = rxp.baud_div >> 1;
        end
      end
      adsc_pkg::RX_START:
      begin
        // A start bit that has gone high by mid-bit was a glitch
        if (tick)
        begin
          nxt_state = rxp.rxd ? adsc_pkg::RX_IDLE : adsc_pkg::RX_DATA;
          nxt_cnt   = rxp.baud_div - 1'b1;
          nxt_bit   = 3'h0;
        end
      end
      adsc_pkg::RX_DATA:
      begin
        if (tick)
        begin
          nxt_sh  = {rxp.rxd, sh_ff[7:1]};
          nxt_cnt = rxp.baud_div - 1'b1;
          nxt_bit = bit_ff + 1'b1;
          if (bit_ff == 3'h7)
            nxt_state = adsc_pkg::RX_STOP;
        end
      end
      adsc_pkg::RX_STOP:
      begin
        if (tick)
          nxt_state = adsc_pkg::RX_IDLE;
      end
      default:
        nxt_state = adsc_pkg::RX_IDLE;
    endcase
    if (!rxp.enable)
      nxt_state = adsc_pkg::RX_IDLE;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      state_ff <= adsc_pkg::RX_IDLE;
      cnt_ff   <= '0;
      bit_ff   <= 3'h0;
      sh_ff    <= 8'h00;
      data_ff  <= 8'h00;
      valid_ff <= 1'b0;
      ferr_ff  <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      bit_ff   <= nxt_bit;
      sh_ff    <= nxt_sh;
      valid_ff <= stop_ok && rxp.enable;
      ferr_ff  <= stop_bad && rxp.enable;
      if (stop_ok)
        data_ff <= sh_ff;
    end
  end

  assign rxp.data      = data_ff;
  assign rxp.valid     = valid_ff;
  assign rxp.frame_err = ferr_ff;
endmodule

// File: adsc_cfg_top.sv
// Air/ground, remote head, GPS source, integrity and altitude correction configuration
// How it works
// - Enabled ground switch drives on-ground versus in-flight state.
// - Display letter is G on ground, F in flight.
// - On ground, ground replies are selected and squitter rate is lowered.
// - Without a ground switch, airborne formats are always used.
// - Enabled remote head may drive every standard user input.
// - Remote head is off, on, or test with a ground maintenance protocol.
// - NMEA integrity option receives at 9600 baud, RMC and RAIM expected.
// - Plain NMEA options receive RMC at 4800 or 9600 baud.
// - Avionics navigator option at 9600 baud; integrity sensor at 19200.
// - Comm-A/B option runs the link at 38400 baud.
// - Disabled option neither receives nor transmits.
// - SIL selectable only for integrity options, else 0; SIL 1 sets SDA 1.
// - NAC choice of 0 or automatic only under integrity options.
// - Any other option forces NAC to 0.
// - Automatic NAC follows the accuracy supplied by the receiver.
// - Pressure altitude corrected by offsets at five points, 2000 to 35000 ft.
// - Each offset limited to -100..+100 ft in 10 ft steps.
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
module adsc_cfg_top #(
  parameter int unsigned DIV_4800  = adsc_pkg::CLK_HZ / adsc_pkg::BAUD_4800,
  parameter int unsigned DIV_9600  = adsc_pkg::CLK_HZ / adsc_pkg::BAUD_9600,
  parameter int unsigned DIV_19200 = adsc_pkg::CLK_HZ / adsc_pkg::BAUD_19200,
  parameter int unsigned DIV_38400 = adsc_pkg::CLK_HZ / adsc_pkg::BAUD_38400,
  parameter int unsigned MSG_WIN   = adsc_pkg::CLK_HZ * adsc_pkg::MSG_WIN_S
) (
  input  wire logic               CLK_SYS,
  input  wire logic               RST_B,
  input  wire logic               HSEL,
  input  wire logic [31:0]        HADDR,
  input  wire logic [1:0]         HTRANS,
  input  wire logic               HWRITE,
  input  wire logic [2:0]         HSIZE,
  input  wire logic [31:0]        HWDATA,
  input  wire logic               HREADY,
  output logic      [31:0]        HRDATA,
  output logic                    HREADYOUT,
  output logic                    HRESP,
  input  wire logic               GND_SW,
  input  wire logic               SER_RXD,
  input  wire logic [3:0]         GPS_NAC,
  input  wire logic signed [17:0] PRESS_ALT,
  input  wire logic [7:0]         LOCAL_KEYS,
  input  wire logic [7:0]         REMOTE_KEYS,
  output logic                    ON_GROUND,
  output logic [7:0]              DISP_LETTER,
  output logic                    GROUND_REPLY,
  output logic                    SQUITTER_SLOW,
  output logic [7:0]              USER_KEYS,
  output logic                    REMOTE_MAINT,
  output logic                    SER_RX_EN,
  output logic                    SER_TX_EN,
  output logic                    SIL_TX,
  output logic                    SDA_TX,
  output logic [3:0]              NAC_TX,
  output logic signed [17:0]      CORR_ALT,
  output logic [7:0]              RX_BYTE,
  output logic                    RX_VALID
);
  localparam int MW = $clog2(MSG_WIN + 1);

  logic [9:0]        ctrl_ff;
  logic signed [4:0] ofs_ff [adsc_pkg::N_PTS];
  logic              wr_ff;
  logic [7:0]        addr_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        gnd_s_ff;
  logic [1:0]        rxd_s_ff;
  logic              on_gnd_ff;
  logic [7:0]        letter_ff;
  logic [7:0]        keys_ff;
  logic              maint_ff;
  logic              sil_ff;
  logic [3:0]        nac_ff;
  logic signed [17:0] alt_ff;
  logic [7:0]        byte_ff;
  logic              bvalid_ff;
  logic              ferr_ff;
  logic [MW-1:0]     win_ff;
  logic [1:0]        msgs_ff;
  logic              stale_ff;
  logic              fast_ff;

  adsc_rx_if rxp ();

  // Offset clamp into the step range; software writes a signed step count
  function automatic logic signed [4:0] clamp_ofs(input logic [31:0] w);
    logic signed [31:0] v;
    v = signed'(w);
    if (v > 32'(adsc_pkg::OFS_MAX))
      clamp_ofs = adsc_pkg::OFS_MAX;
    else if (v < 32'(adsc_pkg::OFS_MIN))
      clamp_ofs = adsc_pkg::OFS_MIN;
    else
      clamp_ofs = v[4:0];
  endfunction

  // Piecewise linear offset in feet; outside the outer points the end value holds
  function automatic logic signed [17:0] corr(input logic signed [17:0] alt,
                                              input logic [24:0] ofs_flat);
    int a;
    int o_lo;
    int o_hi;
    int res;
    a   = int'(alt);
    res = int'(alt) + int'($signed(ofs_flat[4:0])) * adsc_pkg::STEP_FT;
    if (a >= adsc_pkg::PT4)
      res = a + int'($signed(ofs_flat[24:20])) * adsc_pkg::STEP_FT;
    for (int i = 0; i < adsc_pkg::N_PTS - 1; i++)
    begin
      o_lo = int'($signed(ofs_flat[i*5 +: 5])) * adsc_pkg::STEP_FT;
      o_hi = int'($signed(ofs_flat[i*5+5 +: 5])) * adsc_pkg::STEP_FT;
      if (a >= adsc_pkg::pt_ft(i) && a < adsc_pkg::pt_ft(i + 1))
        res = a + o_lo + ((a - adsc_pkg::pt_ft(i)) * (o_hi - o_lo))
              / (adsc_pkg::pt_ft(i + 1) - adsc_pkg::pt_ft(i));
    end
    corr = res[17:0];
  endfunction

  // Bus decode
  wire        acc      = HSEL && HTRANS[1] && HREADY;
  wire [7:0]  a_lo     = HADDR[7:0];
  wire        rd_rx    = acc && !HWRITE && (a_lo == adsc_pkg::A_RXDATA);
  wire        is_ofs   = (addr_ff >= adsc_pkg::A_OFS0) && (addr_ff <= adsc_pkg::A_OFS4);
  wire [2:0]  ofs_idx  = 3'((addr_ff - adsc_pkg::A_OFS0) >> 2);
  wire [2:0]  a_idx    = 3'((a_lo - adsc_pkg::A_OFS0) >> 2);
  wire        a_is_ofs = (a_lo >= adsc_pkg::A_OFS0) && (a_lo <= adsc_pkg::A_OFS4);

  // Configuration decode
  wire        gnd_en   = ctrl_ff[adsc_pkg::C_GND];
  wire [1:0]  rem_mode = ctrl_ff[adsc_pkg::C_REM_LO +: 2];
  wire [2:0]  opt      = ctrl_ff[adsc_pkg::C_OPT_LO +: 3];
  wire        integ    = (opt == adsc_pkg::OPT_NMEA_INT) || (opt == adsc_pkg::OPT_INTEG);
  wire        ser_on   = (opt >= adsc_pkg::OPT_AVNAV) && (opt <= adsc_pkg::OPT_COMMAB);
  wire        on_gnd   = gnd_en && gnd_s_ff[1];
  wire        nac_auto = integ && ctrl_ff[adsc_pkg::C_NAC];
  wire [3:0]  nxt_nac  = nac_auto ? GPS_NAC : 4'h0;
  wire        nxt_sil  = integ && ctrl_ff[adsc_pkg::C_SIL];
  wire        rem_on   = (rem_mode == adsc_pkg::REM_ON) || (rem_mode == adsc_pkg::REM_TEST);
  wire [7:0]  nxt_keys = LOCAL_KEYS | (rem_on ? REMOTE_KEYS : 8'h00);
  wire        msg_end  = rxp.valid && (rxp.data == adsc_pkg::MSG_END);
  wire        win_end  = (win_ff == MW'(MSG_WIN - 1));

  logic [24:0] ofs_flat;
  always_comb
  begin
    for (int i = 0; i < adsc_pkg::N_PTS; i++)
      ofs_flat[i*5 +: 5] = ofs_ff[i];
  end

  logic [adsc_pkg::DIV_W-1:0] div_sel;
  always_comb
  begin
    case (opt)
      adsc_pkg::OPT_NMEA_SLOW: div_sel = adsc_pkg::DIV_W'(DIV_4800);
      adsc_pkg::OPT_NMEA_FAST: div_sel = adsc_pkg::DIV_W'(DIV_9600);
      adsc_pkg::OPT_NMEA_INT:  div_sel = adsc_pkg::DIV_W'(DIV_9600);
      adsc_pkg::OPT_AVNAV:     div_sel = adsc_pkg::DIV_W'(DIV_9600);
      adsc_pkg::OPT_INTEG:     div_sel = adsc_pkg::DIV_W'(DIV_19200);
      adsc_pkg::OPT_COMMAB:    div_sel = adsc_pkg::DIV_W'(DIV_38400);
      default:                 div_sel = adsc_pkg::DIV_W'(DIV_9600);
    endcase
  end

  logic [31:0] nxt_rdata;
  always_comb
  begin
    nxt_rdata = 32'h0;
    if (a_lo == adsc_pkg::A_CTRL)
      nxt_rdata = {22'h0, ctrl_ff};
    else if (a_lo == adsc_pkg::A_STAT)
      nxt_rdata = {12'h0, nac_ff, letter_ff, fast_ff, stale_ff, ferr_ff,
                   maint_ff, SDA_TX, sil_ff, ser_on, on_gnd_ff};
    else if (a_is_ofs)
      nxt_rdata = 32'(signed'(ofs_ff[a_idx]));
    else if (a_lo == adsc_pkg::A_RXDATA)
      nxt_rdata = {23'h0, bvalid_ff, byte_ff};
    else if (a_lo == adsc_pkg::A_ALT)
      nxt_rdata = 32'(signed'(alt_ff));
  end

  assign rxp.baud_div = div_sel;
  assign rxp.enable   = ser_on;
  assign rxp.rxd      = rxd_s_ff[1];

  adsc_uart_rx u_rx (
    .CLK_SYS (CLK_SYS),
    .RST_B   (RST_B),
    .rxp     (rxp)
  );

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      wr_ff    <= 1'b0;
      addr_ff  <= 8'h00;
      rdata_ff <= 32'h0;
      ctrl_ff  <= adsc_pkg::CTRL_RST;
      for (int i = 0; i < adsc_pkg::N_PTS; i++)
        ofs_ff[i] <= 5'sd0;
    end
    else
    begin
      wr_ff   <= acc && HWRITE;
      addr_ff <= a_lo;
      if (acc && !HWRITE)
        rdata_ff <= nxt_rdata;
      if (wr_ff && addr_ff == adsc_pkg::A_CTRL)
        ctrl_ff <= HWDATA[9:0];
      if (wr_ff && is_ofs)
        ofs_ff[ofs_idx] <= clamp_ofs(HWDATA);
    end
  end

  // Two-flop synchronisers for the switch and serial pins
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      gnd_s_ff <= 2'b00;
      rxd_s_ff <= 2'b11;
    end
    else
    begin
      gnd_s_ff <= {gnd_s_ff[0], GND_SW};
      rxd_s_ff <= {rxd_s_ff[0], SER_RXD};
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      on_gnd_ff <= 1'b0;
      letter_ff <= adsc_pkg::LETTER_F;
      keys_ff   <= 8'h00;
      maint_ff  <= 1'b0;
      sil_ff    <= 1'b0;
      nac_ff    <= 4'h0;
      alt_ff    <= 18'sd0;
    end
    else
    begin
      on_gnd_ff <= on_gnd;
      letter_ff <= on_gnd ? adsc_pkg::LETTER_G : adsc_pkg::LETTER_F;
      keys_ff   <= nxt_keys;
      maint_ff  <= (rem_mode == adsc_pkg::REM_TEST);
      sil_ff    <= nxt_sil;
      nac_ff    <= nxt_nac;
      alt_ff    <= corr(PRESS_ALT, ofs_flat);
    end
  end

  // Received byte with a read-to-clear valid flag; a new byte beats the clear
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      byte_ff   <= 8'h00;
      bvalid_ff <= 1'b0;
      ferr_ff   <= 1'b0;
    end
    else
    begin
      if (rxp.valid)
        byte_ff <= rxp.data;
      bvalid_ff <= rxp.valid || (bvalid_ff && !rd_rx);
      ferr_ff   <= rxp.frame_err || (ferr_ff && !rd_rx);
    end
  end

  // Message rate watch over each window: flags a silent or too chatty source
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B || !ser_on)
    begin
      win_ff   <= '0;
      msgs_ff  <= 2'h0;
      stale_ff <= 1'b0;
      fast_ff  <= 1'b0;
    end
    else
    begin
      win_ff <= win_end ? '0 : win_ff + 1'b1;
      if (win_end)
      begin
        stale_ff <= (msgs_ff == 2'h0) && !msg_end;
        fast_ff  <= (msgs_ff == 2'h3);
        msgs_ff  <= 2'(msg_end);
      end
      else if (msg_end && msgs_ff != 2'h3)
        msgs_ff <= msgs_ff + 1'b1;
    end
  end

  assign HRDATA        = rdata_ff;
  assign HREADYOUT     = 1'b1;
  assign HRESP         = 1'b0;
  assign ON_GROUND     = on_gnd_ff;
  assign DISP_LETTER   = letter_ff;
  assign GROUND_REPLY  = on_gnd_ff;
  assign SQUITTER_SLOW = on_gnd_ff;
  assign USER_KEYS     = keys_ff;
  assign REMOTE_MAINT  = maint_ff;
  assign SER_RX_EN     = ser_on;
  assign SER_TX_EN     = ser_on;
  assign SIL_TX        = sil_ff;
  assign SDA_TX        = sil_ff;
  assign NAC_TX        = nac_ff;
  assign CORR_ALT      = alt_ff;
  assign RX_BYTE       = byte_ff;
  assign RX_VALID      = bvalid_ff;
endmodule

// File: adsc_gps_model.sv
// Model of the GPS receiver that sends 8N1 bytes on the serial line
module adsc_gps_model (
  input  wire logic clk_sys,
  output logic      txd
);
  timeunit 1ns;
  timeprecision 100ps;

  initial txd = 1'b1;

  // A zero stop bit breaks framing on purpose; the line idles high between bytes
  task automatic send(input logic [7:0] b, input int div, input logic stop);
    logic [9:0] fr;
    fr = {stop, b, 1'b0};
    @(posedge clk_sys);
    for (int i = 0; i < 10; i++)
    begin
      txd <= fr[i];
      repeat (div) @(posedge clk_sys);
    end
    txd <= 1'b1;
    repeat (2 * div) @(posedge clk_sys);
  endtask
endmodule

// File: adsc_cfg_top_asserts.sv
// Property checker for the source and option configuration block
module adsc_cfg_asserts (
  input wire logic       CLK_SYS,
  input wire logic       RST_B,
  input wire logic       HREADYOUT,
  input wire logic       HRESP,
  input wire logic       GND_SW,
  input wire logic [3:0] GPS_NAC,
  input wire logic [7:0] LOCAL_KEYS,
  input wire logic [7:0] REMOTE_KEYS,
  input wire logic       ON_GROUND,
  input wire logic [7:0] DISP_LETTER,
  input wire logic       GROUND_REPLY,
  input wire logic       SQUITTER_SLOW,
  input wire logic [7:0] USER_KEYS,
  input wire logic       REMOTE_MAINT,
  input wire logic       SER_RX_EN,
  input wire logic       SER_TX_EN,
  input wire logic       SIL_TX,
  input wire logic       SDA_TX,
  input wire logic [3:0] NAC_TX,
  input wire logic       RX_VALID
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);

  sequence link_quiet;
    !SER_RX_EN [*8];
  endsequence

  sequence remote_held;
    REMOTE_MAINT && $past(REMOTE_MAINT) && $past(RST_B);
  endsequence

  letter_shows_state_a: assert property (
    DISP_LETTER == (ON_GROUND ? 8'h47 : 8'h46)) else $error("display letter wrong");
  ground_formats_a: assert property (
    GROUND_REPLY == ON_GROUND && SQUITTER_SLOW == ON_GROUND)
    else $error("ground reply or squitter rate wrong");
  ground_from_switch_a: assert property (
    $rose(ON_GROUND) |-> $past(GND_SW, 3)) else $error("on ground without switch");
  local_keys_pass_a: assert property (
    $past(RST_B) |-> (USER_KEYS & $past(LOCAL_KEYS)) == $past(LOCAL_KEYS))
    else $error("local key lost");
  remote_keys_pass_a: assert property (
    remote_held |-> (USER_KEYS & $past(REMOTE_KEYS)) == $past(REMOTE_KEYS))
    else $error("remote key lost in test mode");
  serial_off_quiet_a: assert property (
    link_quiet |-> !$rose(RX_VALID) && !SER_TX_EN) else $error("disabled link active");
  sda_with_sil_a: assert property (
    SDA_TX == SIL_TX) else $error("integrity and assurance differ");
  nac_auto_follows_a: assert property (
    $past(RST_B) && NAC_TX != 4'h0 |-> NAC_TX == $past(GPS_NAC))
    else $error("accuracy not taken from receiver");
  bus_no_wait_a: assert property (
    HREADYOUT && !HRESP) else $error("bus answer not ready okay");
endmodule

// File: test_adsb_source_and_option_config.sv
// Self-checking testbench of the source and option configuration block
module test_adsb_source_and_option_config;
  timeunit 1ns;
  timeprecision 100ps;

  logic               clk_sys = 1'b0;
  logic               rst_b = 1'b0;
  logic               hsel = 1'b0;
  logic        [31:0] haddr = 32'h0;
  logic        [1:0]  htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic        [31:0] hwdata = 32'h0;
  logic        [2:0]  hsize = 3'h0;
  logic               gnd_sw = 1'b0;
  logic        [3:0]  gps_nac = 4'h9;
  logic signed [17:0] press_alt = 18'sh0;
  logic        [7:0]  local_keys = 8'h0;
  logic        [7:0]  remote_keys = 8'h0;
  wire logic          hready;
  logic        [31:0] hrdata;
  logic               hresp;
  logic               txd;
  logic               on_ground;
  logic        [7:0]  disp_letter;
  logic               ground_reply;
  logic               squitter_slow;
  logic        [7:0]  user_keys;
  logic               remote_maint;
  logic               ser_rx_en;
  logic               ser_tx_en;
  logic               sil_tx;
  logic               sda_tx;
  logic        [3:0]  nac_tx;
  logic signed [17:0] corr_alt;
  logic        [7:0]  rx_byte;
  logic               rx_valid;
  int                 fail_count = 0;
  int                 tests_run = 0;

  always #5 clk_sys = ~clk_sys;

  adsc_gps_model u_gps (.clk_sys(clk_sys), .txd(txd));

  adsc_cfg_top #(.DIV_4800(16), .DIV_9600(8), .DIV_19200(6), .DIV_38400(4),
    .MSG_WIN(2000)) DUT (
    .CLK_SYS(clk_sys), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .GND_SW(gnd_sw), .SER_RXD(txd),
    .GPS_NAC(gps_nac), .PRESS_ALT(press_alt), .LOCAL_KEYS(local_keys),
    .REMOTE_KEYS(remote_keys), .ON_GROUND(on_ground), .DISP_LETTER(disp_letter),
    .GROUND_REPLY(ground_reply), .SQUITTER_SLOW(squitter_slow), .USER_KEYS(user_keys),
    .REMOTE_MAINT(remote_maint), .SER_RX_EN(ser_rx_en), .SER_TX_EN(ser_tx_en),
    .SIL_TX(sil_tx), .SDA_TX(sda_tx), .NAC_TX(nac_tx), .CORR_ALT(corr_alt),
    .RX_BYTE(rx_byte), .RX_VALID(rx_valid));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    haddr  <= {24'h0, a};
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
    settle(3);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    bus(1'b0, a, 32'h0, x);
    #1;
  endtask

  task automatic t_reset;
    logic [31:0] x;
    rd(8'h00, x);
    check("ctrl", x, 32'h0);
    check("outs", 32'({ser_rx_en, ser_tx_en, on_ground, disp_letter}), 32'h46);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, x);
    check("unmapped", x, 32'h0);
  endtask

  task automatic t_ground;
    @(posedge clk_sys);
    gnd_sw <= 1'b1;
    settle(6);
    check("no switch", 32'({on_ground, disp_letter}), 32'h46);
    wr(8'h00, 32'h1);
    settle(3);
    check("ground", 32'({on_ground, ground_reply, squitter_slow, disp_letter}),
      32'h747);
    @(posedge clk_sys);
    gnd_sw <= 1'b0;
    settle(5);
    check("flight", 32'({on_ground, ground_reply, squitter_slow, disp_letter}),
      32'h046);
    wr(8'h00, 32'h0);
  endtask

  task automatic t_remote;
    logic [7:0] ek [4] = '{8'h01, 8'h81, 8'h81, 8'h01};
    @(posedge clk_sys);
    local_keys  <= 8'h01;
    remote_keys <= 8'h80;
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, 32'(i) << 1);
      settle(2);
      check("keys", 32'({user_keys, remote_maint}), 32'({ek[i], i == 2}));
    end
  endtask

  task automatic t_opts;
    int          dv [8] = '{8, 8, 16, 8, 8, 6, 4, 8};
    logic [31:0] x;
    logic        en;
    logic        ig;
    for (int o = 0; o < 8; o++)
    begin
      @(posedge clk_sys);
      gps_nac <= 4'(o + 5);
      en = (o >= 1 && o <= 6);
      ig = (o == 4 || o == 5);
      wr(8'h00, 32'h300 | (32'(o) << 4));
      check("ser en", 32'({ser_rx_en, ser_tx_en}), 32'({en, en}));
      check("sil nac", 32'({sil_tx, sda_tx, nac_tx}), 32'({ig, ig, ig ? 4'(o + 5) : 4'h0}));
      u_gps.send(8'ha0 + 8'(o), dv[o], 1'b1);
      settle(4);
      rd(8'h1c, x);
      check("rx valid", 32'(x[8]), 32'(en));
      if (en)
        check("rx byte", 32'(x[7:0]), 32'(8'ha0 + 8'(o)));
    end
    wr(8'h00, 32'h050);
    check("sil fixed", 32'({sil_tx, sda_tx, nac_tx}), 32'h0);
  endtask

  task automatic t_frame;
    logic [31:0] x;
    wr(8'h00, 32'h030);
    u_gps.send(8'h3c, 8, 1'b0);
    settle(4);
    rd(8'h04, x);
    check("frame err", 32'(x[5]), 32'h1);
    rd(8'h1c, x);
    check("bad dropped", 32'(x[8]), 32'h0);
    rd(8'h04, x);
    check("err cleared", 32'(x[5]), 32'h0);
    u_gps.send(8'hc3, 8, 1'b1);
    settle(4);
    check("rx pins", 32'({rx_valid, rx_byte}), 32'h1c3);
    rd(8'h1c, x);
    check("good byte", 32'(x[8:0]), 32'h1c3);
  endtask

  task automatic t_alt;
    int          a [8] = '{-500, 2000, 5000, 13000, 18000, 30000, 35000, 40000};
    int          e [8] = '{-400, 2100, 5000, 12950, 18000, 30035, 34970, 39970};
    logic [31:0] x;
    wr(8'h08, 32'd10);
    wr(8'h0c, 32'hffff_fff6);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'd15);
    wr(8'h18, 32'hffff_fffd);
    rd(8'h14, x);
    check("ofs clamp", x, 32'd10);
    rd(8'h18, x);
    check("ofs neg", x, 32'hffff_fffd);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      press_alt <= 18'(a[i]);
      settle(2);
      check("corr alt", 32'(corr_alt), 32'(18'(e[i])));
    end
    rd(8'h20, x);
    check("alt reg", x, 32'd39970);
  endtask

  // One message in the first window, none in the second
  task automatic t_rate;
    logic [31:0] x;
    wr(8'h00, 32'h000);
    wr(8'h00, 32'h030);
    u_gps.send(8'h0a, 8, 1'b1);
    settle(2000);
    rd(8'h04, x);
    check("rate in range", 32'(x[7:6]), 32'h0);
    settle(2000);
    rd(8'h04, x);
    check("source stale", 32'(x[7:6]), 32'h1);
  endtask

  task automatic report_and_stop;
    $display("Mismatches %0d of %0d comparisons", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_ground();
    t_remote();
    t_opts();
    t_frame();
    t_rate();
    t_alt();
    report_and_stop();
  end

  // About seven times the expected run length
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    fail_count++;
    report_and_stop();
  end
endmodule

bind adsc_cfg_top adsc_cfg_asserts u_chk (
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .GND_SW(GND_SW), .GPS_NAC(GPS_NAC), .LOCAL_KEYS(LOCAL_KEYS),
  .REMOTE_KEYS(REMOTE_KEYS), .ON_GROUND(ON_GROUND), .DISP_LETTER(DISP_LETTER),
  .GROUND_REPLY(GROUND_REPLY), .SQUITTER_SLOW(SQUITTER_SLOW), .USER_KEYS(USER_KEYS),
  .REMOTE_MAINT(REMOTE_MAINT), .SER_RX_EN(SER_RX_EN), .SER_TX_EN(SER_TX_EN),
  .SIL_TX(SIL_TX), .SDA_TX(SDA_TX), .NAC_TX(NAC_TX), .RX_VALID(RX_VALID));
